// ---- design/scc_pkg.sv ----
// Package: register map, field positions and reset values of the block
package scc_pkg;
  // Register byte offsets
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] stat_off = 8'h04;
  localparam logic [7:0] data_off = 8'h08;
  localparam logic [7:0] mask_off = 8'h0c;
  // Control register fields
  localparam int ctrl_mp_bit = 0;
  localparam int ctrl_re_bit = 1;
  localparam int ctrl_te_bit = 2;
  localparam int ctrl_rie_bit = 3;
  localparam int ctrl_width = 4;
  localparam logic [3:0] ctrl_rst = 4'h0;
  // Status register fields (mask register shares the low two)
  localparam int stat_full_bit = 0;
  localparam int stat_err_bit = 1;
  localparam int stat_wait_bit = 2;
  localparam int stat_pin_bit = 3;
  localparam int flag_width = 2;
  localparam logic [1:0] flag_rst = 2'h0;
  localparam logic [1:0] mask_rst = 2'h0;
  localparam int data_width = 8;
  localparam logic [7:0] data_rst = 8'h00;
endpackage

// ---- design/scc_top.sv ----
// Serial channel control bits: enables, pin role, receive request gating
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module scc_top
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd_pin,
  input wire logic rx_frame_done,
  input wire logic rx_frame_err,
  input wire logic rx_mpb,
  input wire logic [7:0] rx_frame_data,
  output logic rx_enable,
  output logic tx_enable,
  output logic rx_serial_in,
  output logic rx_pin_is_serial,
  output logic port_in,
  output logic receive_full_irq,
  output logic receive_error_irq,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [3:0] ctrl_r;
  logic [1:0] serial_status_reg_r;
  logic [1:0] mask_r;
  logic [7:0] data_r;
  logic pin_s1_r;
  logic pin_s2_r;
  logic setup;
  logic done;
  logic wr_done;
  logic stat_rd;
  logic mp_frame_seen;
  logic accept;
  logic [1:0] flag_set;
  logic [31:0] rd_mux;
  logic mapped;

  // Address hit decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake terms
  assign setup = psel & ~penable & ~pready;
  assign done = psel & penable & pready;
  assign wr_done = done & pwrite & ~pslverr;
  assign stat_rd = done & ~pwrite & hit(paddr, scc_pkg::stat_off);
  assign mapped = hit(paddr, scc_pkg::ctrl_off) | hit(paddr, scc_pkg::stat_off)
    | hit(paddr, scc_pkg::data_off) | hit(paddr, scc_pkg::mask_off);

  // Pin synchroniser, two flops before any use
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end
    else
    begin
      pin_s1_r <= rxd_pin;
      pin_s2_r <= pin_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame acceptance
  // A frame counts only while receiving and, in multiprocessor mode,
  // only once the multiprocessor bit is one
  assign mp_frame_seen = rx_frame_done & rx_mpb;
  assign accept = rx_frame_done & ctrl_r[scc_pkg::ctrl_re_bit]
    & (~ctrl_r[scc_pkg::ctrl_mp_bit] | rx_mpb);
  assign flag_set = {accept & rx_frame_err, accept & ~rx_frame_err};

  // Control register; hardware drops multiprocessor mode on a flagged frame while receiving
  always_ff @(posedge clock)
  begin
    if (rst)
      ctrl_r <= scc_pkg::ctrl_rst;
    else if (wr_done && hit(paddr, scc_pkg::ctrl_off))
      ctrl_r <= pwdata[scc_pkg::ctrl_width-1:0];
    else if (mp_frame_seen && ctrl_r[scc_pkg::ctrl_re_bit])
      ctrl_r[scc_pkg::ctrl_mp_bit] <= 1'b0;
  end

  // Mask register
  always_ff @(posedge clock)
  begin
    if (rst)
      mask_r <= scc_pkg::mask_rst;
    else if (wr_done && hit(paddr, scc_pkg::mask_off))
      mask_r <= pwdata[scc_pkg::flag_width-1:0];
  end

  // Sticky status flags; a read clears only the bits it reported, so an
  // event landing between setup and access is not lost; set wins
  always_ff @(posedge clock)
  begin
    if (rst)
      serial_status_reg_r <= scc_pkg::flag_rst;
    else
      serial_status_reg_r <= (serial_status_reg_r
        & ~({2{stat_rd}} & prdata[scc_pkg::flag_width-1:0]))
        | flag_set;
  end

  // Received data holding register
  always_ff @(posedge clock)
  begin
    if (rst)
      data_r <= scc_pkg::data_rst;
    else if (accept && !rx_frame_err)
      data_r <= rx_frame_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data selection
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      scc_pkg::ctrl_off: rd_mux[scc_pkg::ctrl_width-1:0] = ctrl_r;
      scc_pkg::stat_off:
      begin
        rd_mux[scc_pkg::flag_width-1:0] = serial_status_reg_r;
        rd_mux[scc_pkg::stat_wait_bit] = ctrl_r[scc_pkg::ctrl_mp_bit];
        rd_mux[scc_pkg::stat_pin_bit] = pin_s2_r;
      end
      scc_pkg::data_off: rd_mux[scc_pkg::data_width-1:0] = data_r;
      scc_pkg::mask_off: rd_mux[scc_pkg::flag_width-1:0] = mask_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // APB answer: one wait-free access cycle after setup
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enables, pin role and request outputs
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rx_enable <= 1'b0;
      tx_enable <= 1'b0;
      rx_pin_is_serial <= 1'b0;
      rx_serial_in <= 1'b1;
      port_in <= 1'b1;
    end
    else
    begin
      rx_enable <= ctrl_r[scc_pkg::ctrl_re_bit];
      rx_pin_is_serial <= ctrl_r[scc_pkg::ctrl_re_bit];
      rx_serial_in <= ctrl_r[scc_pkg::ctrl_re_bit] ? pin_s2_r : 1'b1;
      port_in <= ctrl_r[scc_pkg::ctrl_re_bit] ? 1'b1 : pin_s2_r;
      tx_enable <= ctrl_r[scc_pkg::ctrl_te_bit];
    end
  end

  // Requests gated by receive interrupt enable; irq also by mask
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      receive_full_irq <= 1'b0;
      receive_error_irq <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      receive_full_irq <= ctrl_r[scc_pkg::ctrl_rie_bit]
        & serial_status_reg_r[scc_pkg::stat_full_bit];
      receive_error_irq <= ctrl_r[scc_pkg::ctrl_rie_bit]
        & serial_status_reg_r[scc_pkg::stat_err_bit];
      irq <= ctrl_r[scc_pkg::ctrl_rie_bit]
        & |(serial_status_reg_r & mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence frame_in_mp_wait;
    rx_frame_done && !rx_mpb && ctrl_r[scc_pkg::ctrl_mp_bit];
  endsequence

  AST_MP_WITHHOLD: assert property (@(posedge clock) disable iff (rst)
    frame_in_mp_wait ##0 !stat_rd |=> !$rose(serial_status_reg_r[0]))
    else $error("Flag set while waiting for multiprocessor frame");

  AST_MP_RELEASE: assert property (@(posedge clock) disable iff (rst)
    rx_frame_done && rx_mpb && ctrl_r[scc_pkg::ctrl_re_bit]
    && !(wr_done && hit(paddr, scc_pkg::ctrl_off))
    |=> !ctrl_r[scc_pkg::ctrl_mp_bit] && (serial_status_reg_r != 2'h0))
    else $error("Flagged frame did not end multiprocessor wait");

  AST_RX_OFF: assert property (@(posedge clock) disable iff (rst)
    !ctrl_r[scc_pkg::ctrl_re_bit] && !stat_rd
    |=> serial_status_reg_r == $past(serial_status_reg_r)
    && !rx_enable && !rx_pin_is_serial && port_in == $past(pin_s2_r))
    else $error("Reception or pin role wrong while disabled");

  AST_RX_ON: assert property (@(posedge clock) disable iff (rst)
    ctrl_r[scc_pkg::ctrl_re_bit] |=> rx_enable && rx_pin_is_serial
    && rx_serial_in == $past(pin_s2_r))
    else $error("Receive pin not serial input while enabled");

  AST_RX_DATA: assert property (@(posedge clock) disable iff (rst)
    accept && !rx_frame_err |=> data_r == $past(rx_frame_data))
    else $error("Received frame data not captured");

  AST_TX_GATE: assert property (@(posedge clock) disable iff (rst)
    tx_enable |-> $past(ctrl_r[scc_pkg::ctrl_te_bit]))
    else $error("Transmit enabled without enable bit");

  AST_RIE_BLOCK: assert property (@(posedge clock) disable iff (rst)
    !ctrl_r[scc_pkg::ctrl_rie_bit] |=> !receive_full_irq
    && !receive_error_irq && !irq)
    else $error("Receive request raised while disabled");

  AST_RIE_PASS: assert property (@(posedge clock) disable iff (rst)
    ctrl_r[scc_pkg::ctrl_rie_bit] && serial_status_reg_r[0]
    |=> receive_full_irq)
    else $error("Receive full request not raised");

endmodule // scc_top

// ---- verification/scc_station.sv ----
// Remote station model: frame reports and raw receive pin level
`timescale 1ns/10ps
module scc_station
(
  input wire logic clock,
  input wire logic go,
  input wire logic mpb_v,
  input wire logic err_v,
  input wire logic [7:0] byte_v,
  input wire logic pin_v,
  output logic rxd_pin,
  output logic rx_frame_done,
  output logic rx_frame_err,
  output logic rx_mpb,
  output logic [7:0] rx_frame_data
);
  // Quiet line and no frame at time zero
  initial
  begin
    rxd_pin = 1'b1;
    rx_frame_done = 1'b0;
    rx_frame_err = 1'b0;
    rx_mpb = 1'b0;
    rx_frame_data = 8'h00;
  end
  // One-cycle frame pulse; qualifiers scramble outside it
  always @(posedge clock)
  begin
    rxd_pin <= pin_v;
    rx_frame_done <= go;
    rx_frame_err <= go ? err_v : ~rx_frame_err;
    rx_mpb <= go ? mpb_v : ~rx_mpb;
    rx_frame_data <= go ? byte_v : ~rx_frame_data;
  end
endmodule // scc_station

// ---- verification/tb_serial_channel_control_bits.sv ----
// Testbench: enables, pin role and receive request gating
`timescale 1ns/10ps
module tb_serial_channel_control_bits;
  logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, go = 1'b0, mpb_v = 1'b0, err_v = 1'b0;
  logic pin_v = 1'b1, ev, pready, pslverr, rx_enable, tx_enable;
  logic rxd_pin, fdone, ferr, fmpb, rx_serial_in, rx_pin_is_serial;
  logic port_in, receive_full_irq, receive_error_irq, irq;
  logic [7:0] paddr = 8'h00, byte_v = 8'h00, fdata;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  int error_cnt = 0, n_tests = 0;
  always #12.5 clock = ~clock;
  scc_top uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd_pin(rxd_pin),
    .rx_frame_done(fdone), .rx_frame_err(ferr), .rx_mpb(fmpb),
    .rx_frame_data(fdata), .rx_enable(rx_enable), .tx_enable(tx_enable),
    .rx_serial_in(rx_serial_in), .rx_pin_is_serial(rx_pin_is_serial),
    .port_in(port_in), .receive_full_irq(receive_full_irq),
    .receive_error_irq(receive_error_irq), .irq(irq));
  scc_station stn (.clock(clock), .go(go), .mpb_v(mpb_v), .err_v(err_v),
    .byte_v(byte_v), .pin_v(pin_v), .rxd_pin(rxd_pin),
    .rx_frame_done(fdone), .rx_frame_err(ferr), .rx_mpb(fmpb),
    .rx_frame_data(fdata));
  //////////////////////////////////////////////////////////////////////
  // APB transfer; read data and error taken at the pready edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
    end
    while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // One frame from the station, then let flags and requests settle
  task frame(input logic m, input logic e, input logic [7:0] d);
    @(posedge clock);
    go <= 1'b1;
    mpb_v <= m;
    err_v <= e;
    byte_v <= d;
    @(posedge clock);
    go <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  //////////////////////////////////////////////////////////////////////
  // Reset values and unmapped access
  task t_reset;
    apb(1'b0, scc_pkg::ctrl_off, 32'h0);
    chk(rv, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({rv[30:0], ev}, 32'h1);
  endtask
  // Receive off: frame ignored, pin is a port
  task t_rx_off;
    apb(1'b1, scc_pkg::ctrl_off, 32'h8);
    pin_v <= 1'b0;
    frame(1'b0, 1'b0, 8'h33);
    chk({port_in, rx_pin_is_serial, rx_enable, receive_full_irq}, 0);
    apb(1'b0, scc_pkg::stat_off, 32'h0);
    chk(rv & 32'h3, 32'h0);
  endtask
  // Receive on: frame stored, pin is serial input, request raised
  task t_rx_on;
    apb(1'b1, scc_pkg::mask_off, 32'h1);
    apb(1'b1, scc_pkg::ctrl_off, 32'ha);
    frame(1'b0, 1'b0, 8'ha5);
    chk({rx_enable, rx_pin_is_serial, rx_serial_in, port_in}, 32'hd);
    chk({receive_full_irq, irq}, 32'h3);
    apb(1'b0, scc_pkg::data_off, 32'h0);
    chk(rv, 32'ha5);
    apb(1'b0, scc_pkg::stat_off, 32'h0);
    chk(rv & 32'h3, 32'h1);
    repeat (2) @(posedge clock);
    chk({receive_full_irq, irq}, 32'h0);
    pin_v <= 1'b1;
  endtask
  // Receive interrupt enable off blocks the error request
  task t_rie;
    apb(1'b1, scc_pkg::ctrl_off, 32'h2);
    frame(1'b0, 1'b1, 8'h00);
    chk({receive_error_irq, irq}, 32'h0);
    apb(1'b1, scc_pkg::ctrl_off, 32'ha);
    repeat (2) @(posedge clock);
    chk({receive_error_irq, irq}, 32'h2);
    apb(1'b1, scc_pkg::mask_off, 32'h3);
    repeat (2) @(posedge clock);
    chk({receive_error_irq, irq}, 32'h3);
    apb(1'b0, scc_pkg::stat_off, 32'h0);
    chk(rv & 32'h3, 32'h2);
  endtask
  // Multiprocessor mode: unflagged frame dropped, flagged frame taken
  task t_mp;
    apb(1'b1, scc_pkg::ctrl_off, 32'hb);
    frame(1'b0, 1'b0, 8'h11);
    chk(receive_full_irq, 32'h0);
    apb(1'b0, scc_pkg::stat_off, 32'h0);
    chk(rv & 32'h7, 32'h4);
    frame(1'b1, 1'b0, 8'h22);
    chk(receive_full_irq, 32'h1);
    apb(1'b0, scc_pkg::ctrl_off, 32'h0);
    chk(rv, 32'ha);
  endtask
  // Transmit enable follows its control bit
  task t_tx;
    apb(1'b1, scc_pkg::ctrl_off, 32'h4);
    repeat (3) @(posedge clock);
    chk(tx_enable, 32'h1);
    apb(1'b1, scc_pkg::ctrl_off, 32'h0);
    repeat (3) @(posedge clock);
    chk(tx_enable, 32'h0);
  endtask
  //////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task finish_test;
    $display("errors %0d of %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial
  begin
    #100000;
    error_cnt++;
    finish_test;
  end
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_rx_off;
    t_rx_on;
    t_rie;
    t_mp;
    t_tx;
    finish_test;
  end
endmodule // tb_serial_channel_control_bits
